//--- logic/ddr_switch_pkg.sv
// Constants, register layouts and modes shared by the octal DDR switch logic.
// Assumes one 125 MHz system clock; serial pins are sampled, not used as clocks.
`default_nettype none

package ddr_switch_pkg;

   // ==========================================================================
   // Serial protocol
   // ==========================================================================
   localparam logic [7:0] CMD_RD_PARAM = 8'h5A;
   localparam logic [15:0] CMD_END_BIT = 16'h0008;
   localparam logic [15:0] ADDR_END_BIT = 16'h0020;
   localparam logic [15:0] DATA_START_BIT = 16'h0028;
   localparam logic [15:0] BIT_COUNT_MAX = 16'hFFFF;
   localparam int SYNC_STAGES = 3;
   localparam logic [1:0] STRAP_WAIT = 2'h3;
   localparam logic [3:0] PIN_IDLE = 4'h1;

   // ==========================================================================
   // Parameter space layout
   // ==========================================================================
   localparam logic [5:0] HDR0_WIDX = 6'h02;
   localparam logic [5:0] HDR1_WIDX = 6'h03;
   localparam logic [5:0] TBL_WIDX = 6'h0C;
   localparam logic [23:0] TBL_PTR = 24'h000030;
   localparam logic [7:0] ID_LSB = 8'h0A;
   localparam logic [7:0] ID_MSB = 8'hFF;
   localparam logic [7:0] REV_MAJOR = 8'h01;
   localparam logic [7:0] REV_MINOR = 8'h00;
   localparam logic [7:0] TBL_WORDS_MAX = 8'h08;
   localparam logic [7:0] SEQ_LEN_MAX = 8'h07;
   localparam logic [2:0] NUM_SLOTS = 3'h4;
   localparam int TBL_DEPTH = 8;

   // ==========================================================================
   // Octal DDR target settings
   // ==========================================================================
   localparam logic [2:0] DRV_TYPE0 = 3'h0;
   localparam logic [2:0] DRV_BOOT = 3'h1;
   localparam logic [4:0] OCT_DUMMY = 5'h14;
   localparam logic [4:0] BOOT_DUMMY = 5'h08;
   localparam int OCT_FREQ_MIN_MHZ = 100;

   // ==========================================================================
   // Register port
   // ==========================================================================
   localparam logic [7:0] REG_TBL_LAST = 8'h1C;
   localparam logic [7:0] REG_CTRL = 8'h20;
   localparam logic [7:0] REG_STATUS = 8'h24;

   typedef struct packed {
      logic [22:0] pad;
      logic rearm;
      logic [7:0] tbl_len;
   } ctrl_s;

   localparam ctrl_s CTRL_RESET = '{pad: 23'h0, rearm: 1'b0, tbl_len: TBL_WORDS_MAX};

   typedef struct packed {
      logic [15:0] pad;
      logic [7:0] discards;
      logic [2:0] pad2;
      logic busy;
      logic [2:0] slot;
      logic octal;
   } status_s;

endpackage : ddr_switch_pkg

`default_nettype wire

//--- logic/table_mem_if.sv
// Carrier between the switch logic and its sequence table memory.
// Assumes the memory answers a read index with data one clock later.
`default_nettype none

interface table_mem_if;
   logic wr_en;
   logic [2:0] wr_idx;
   logic [31:0] wr_data;
   logic [2:0] rd_idx;
   logic [31:0] rd_data;

   modport mem (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
   modport user (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
endinterface : table_mem_if

`default_nettype wire

//--- logic/param_table_mem.sv
// Eight-word store for the four command sequence slots, registered read.
// Assumes a single writer and a reader that tolerates one cycle of latency.
`default_nettype none

module param_table_mem (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_clock_en,
   table_mem_if.mem mem_port
);
   logic [31:0] words [ddr_switch_pkg::TBL_DEPTH];

   // The array itself is not reset; software loads it before arming.
   always_ff @(posedge i_clock) begin
      if (i_clock_en && mem_port.wr_en) begin
         words[mem_port.wr_idx] <= mem_port.wr_data;
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mem_port.rd_data <= 32'h0;
      end else if (i_clock_en) begin
         mem_port.rd_data <= words[mem_port.rd_idx];
      end
   end
endmodule : param_table_mem

`default_nettype wire

//--- logic/ddr_switch_target.sv
// Memory-side logic that serves the parameter header and sequence table over the
// single-line serial bus and recognises the mode-change frames that switch it to octal DDR.
// Assumes the serial clock is slow enough to be oversampled by the 125 MHz system clock.
//
// Functional notes
// R1: Host frames each sequence with chip select low, bytes, then chip select high.
// R2: Each sequence occupies two consecutive table words, an eight-byte slot.
// R3: Slot byte one is length 0..7; the following seven are the bytes sent.
// R4: A zero length means the host sends nothing for that slot.
// R5: Host ignores slot bytes past the length; they may hold anything.
// R6: At most four sequences exist, so four slots.
// R7: Host sends exactly eight clocks per byte, no more, no fewer.
// R8: A frame whose clock count differs from the slot length is discarded.
// R9: Sequences are expected strictly in slot order; enable frames precede their targets.
// R10: After the sequences: octal DDR, driver type 0, 20 dummy cycles, 100MHz capable.
// R11: Host reads parameters first because switching changes parameter reads.
// R12: A device already booting in octal DDR needs no switch.
// R13: Header top byte is the table size in words, one-based.
// R14: Slots beyond the stated table length count as not implemented.
// R15: Header major revision reads 01h and minor revision reads 00h.
// R16: Header ID low byte 0Ah, high byte FFh in second word bits 31:24.
// R17: Second header word low 24 bits hold the word-aligned table byte pointer.
// R18: Host runs slots one to four in order, one frame at a time.
//
// Local design decisions: the strobed register port and the address map.
`default_nettype none

module ddr_switch_target (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_clock_en,
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic i_si,
   input wire logic i_boot_octal,
   output logic o_so,
   output logic o_so_oe_n,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_octal_ddr,
   output logic [2:0] o_drv_type,
   output logic [4:0] o_dummy_cycles
);
   typedef enum {S_IDLE, S_FETCH_A, S_FETCH_B, S_CHECK} check_e;

   // A slot is live when its words lie inside the table and its length is usable.
   function automatic logic slot_live(input logic [2:0] slot, input logic [7:0] tlen, input logic [7:0] slen);
      logic [7:0] need;
      need = {4'h0, slot, 1'b0} + 8'h02;
      slot_live = (need <= tlen) && (slen != 8'h00) && (slen <= ddr_switch_pkg::SEQ_LEN_MAX);
   endfunction : slot_live

   // ==========================================================================
   // Pin synchronisers
   // ==========================================================================
   logic [3:0] pin_in;
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic [3:0] pin_s3;
   assign pin_in = {i_boot_octal, i_si, i_sck, i_cs_n};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge i_clock or posedge i_sys_rst) begin
            // Reset levels match the idle pins, so no false edge or strap follows reset.
            if (i_sys_rst) begin
               pin_s1[gi] <= ddr_switch_pkg::PIN_IDLE[gi];
               pin_s2[gi] <= ddr_switch_pkg::PIN_IDLE[gi];
               pin_s3[gi] <= ddr_switch_pkg::PIN_IDLE[gi];
            end else if (i_clock_en) begin
               pin_s1[gi] <= pin_in[gi];
               pin_s2[gi] <= pin_s1[gi];
               pin_s3[gi] <= pin_s2[gi];
            end
         end
      end
   endgenerate

   logic [3:0] pin_lvl;
   wire [3:0] pin_agree = ~(pin_s2 ^ pin_s3);
   wire [3:0] pin_change = pin_agree & (pin_s3 ^ pin_lvl);
   wire sck_rise = pin_change[1] & pin_s3[1];
   wire sck_fall = pin_change[1] & ~pin_s3[1];
   wire cs_fall = pin_change[0] & ~pin_s3[0];
   wire cs_rise = pin_change[0] & pin_s3[0];
   wire cs_active = ~pin_lvl[0];
   wire si_lvl = pin_lvl[2];

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pin_lvl <= ddr_switch_pkg::PIN_IDLE;
      end else if (i_clock_en) begin
         pin_lvl <= pin_lvl ^ pin_change;
      end
   end

   // ==========================================================================
   // Frame receiver
   // ==========================================================================
   logic [15:0] bit_cnt;
   logic [55:0] rx;
   logic [7:0] cmd;
   logic [23:0] rd_addr;
   logic octal;

   wire [55:0] next_rx = {rx[54:0], si_lvl};
   wire [15:0] next_bit_cnt = (bit_cnt == ddr_switch_pkg::BIT_COUNT_MAX) ? bit_cnt : bit_cnt + 16'h0001;
   // Once switched, single-line parameter reads are no longer answered.
   wire is_read = (bit_cnt >= ddr_switch_pkg::CMD_END_BIT) && (cmd == ddr_switch_pkg::CMD_RD_PARAM) && !octal; // see R11

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bit_cnt <= 16'h0000;
         rx <= 56'h0;
         cmd <= 8'h00;
         rd_addr <= 24'h000000;
      end else if (i_clock_en) begin
         if (cs_fall) begin
            bit_cnt <= 16'h0000;
            cmd <= 8'h00;
         end else if (cs_active && sck_rise) begin
            rx <= next_rx;
            bit_cnt <= next_bit_cnt;
            if (next_bit_cnt == ddr_switch_pkg::CMD_END_BIT) begin
               cmd <= next_rx[7:0];
            end
            if (next_bit_cnt == ddr_switch_pkg::ADDR_END_BIT) begin
               rd_addr <= next_rx[23:0];
            end
         end
      end
   end

   // ==========================================================================
   // Parameter read path
   // ==========================================================================
   table_mem_if tbl_bus ();
   ddr_switch_pkg::ctrl_s ctrl;
   check_e chk_state;
   logic [2:0] slot;

   wire [15:0] data_bits = bit_cnt - ddr_switch_pkg::DATA_START_BIT;
   wire [23:0] cur_addr = rd_addr + {11'h000, data_bits[15:3]};
   wire [5:0] cur_widx = cur_addr[7:2];
   wire [5:0] tbl_off = cur_widx - ddr_switch_pkg::TBL_WIDX;
   wire addr_low = (cur_addr[23:8] == 16'h0000);
   wire sel_hdr0 = addr_low && (cur_widx == ddr_switch_pkg::HDR0_WIDX);
   wire sel_hdr1 = addr_low && (cur_widx == ddr_switch_pkg::HDR1_WIDX);
   wire sel_tbl = addr_low && (tbl_off < 6'(ddr_switch_pkg::TBL_DEPTH)) && ({2'h0, tbl_off} < ctrl.tbl_len); // see R14
   wire [31:0] hdr0 = {ctrl.tbl_len, ddr_switch_pkg::REV_MAJOR, ddr_switch_pkg::REV_MINOR,
                       ddr_switch_pkg::ID_LSB}; // see R13 see R15 see R16
   wire [31:0] hdr1 = {ddr_switch_pkg::ID_MSB, ddr_switch_pkg::TBL_PTR}; // see R16 see R17
   wire checking = (chk_state == S_FETCH_A) || (chk_state == S_FETCH_B);

   logic [1:0] src;
   wire [31:0] rd_word = (src == 2'h1) ? hdr0 :
                         (src == 2'h2) ? hdr1 :
                         (src == 2'h3) ? tbl_bus.rd_data : 32'h0;
   // Words are sent least significant byte first.
   wire [7:0] rd_byte = rd_word[{cur_addr[1:0], 3'h0} +: 8];
   wire drive_now = cs_active && is_read && (bit_cnt >= ddr_switch_pkg::DATA_START_BIT);

   assign tbl_bus.rd_idx = checking ? {slot[1:0], (chk_state == S_FETCH_B)} : tbl_off[2:0]; // see R2

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         src <= 2'h0;
         o_so <= 1'b0;
         o_so_oe_n <= 1'b1;
      end else if (i_clock_en) begin
         src <= sel_hdr0 ? 2'h1 : sel_hdr1 ? 2'h2 : sel_tbl ? 2'h3 : 2'h0;
         o_so_oe_n <= ~drive_now;
         if (drive_now && sck_fall) begin
            o_so <= rd_byte[3'h7 - data_bits[2:0]];
         end
      end
   end

   // ==========================================================================
   // Register port
   // ==========================================================================
   logic [7:0] discards;
   wire wr_tbl = i_wr && (i_addr <= ddr_switch_pkg::REG_TBL_LAST) && (i_addr[1:0] == 2'h0);
   wire wr_ctrl = i_wr && (i_addr == ddr_switch_pkg::REG_CTRL);
   wire rearm = wr_ctrl && i_wdata[8];
   ddr_switch_pkg::status_s status;

   assign tbl_bus.wr_en = wr_tbl && i_clock_en;
   assign tbl_bus.wr_idx = i_addr[4:2];
   assign tbl_bus.wr_data = i_wdata;
   assign status = '{pad: 16'h0, discards: discards, pad2: 3'h0, busy: (chk_state != S_IDLE),
                     slot: slot, octal: octal};

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl <= ddr_switch_pkg::CTRL_RESET;
         o_rdata <= 32'h0;
      end else if (i_clock_en) begin
         if (wr_ctrl) begin
            ctrl <= '{pad: 23'h0, rearm: 1'b0, tbl_len: i_wdata[7:0]};
         end
         o_rdata <= (i_rd && i_addr == ddr_switch_pkg::REG_CTRL) ? ctrl :
                    (i_rd && i_addr == ddr_switch_pkg::REG_STATUS) ? status : 32'h0;
      end
   end

   param_table_mem u_table (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_clock_en(i_clock_en),
      .mem_port(tbl_bus.mem)
   );

   // ==========================================================================
   // Sequence checker
   // ==========================================================================
   logic pending;
   logic [31:0] word_a;
   logic [1:0] strap_cnt;
   logic strap_done;
   wire [7:0] seq_len = word_a[31:24];
   wire live = slot_live(slot, ctrl.tbl_len, seq_len); // see R4 see R14
   // Only the first seq_len bytes count; the rest of the slot is don't-care.
   wire [55:0] expect_all = {word_a[23:0], tbl_bus.rd_data};
   wire [5:0] len_bits = {seq_len[2:0], 3'h0};
   wire [55:0] len_mask = ~(56'hFFFFFFFFFFFFFF << len_bits);
   wire [55:0] expect_seq = expect_all >> (6'h38 - len_bits); // see R3 see R5
   wire clocks_ok = (bit_cnt == {10'h000, seq_len[2:0], 3'h0}); // see R7 see R8
   wire match = clocks_ok && ((rx & len_mask) == (expect_seq & len_mask));
   wire last_slot = (slot == ddr_switch_pkg::NUM_SLOTS - 3'h1); // see R6
   wire frame_end = cs_rise && !is_read && !octal;
   wire accept = (chk_state == S_CHECK) && live && pending && match;
   wire reject = (chk_state == S_CHECK) && live && pending && !match;

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         chk_state <= S_IDLE;
         pending <= 1'b0;
         word_a <= 32'h0;
         slot <= 3'h0;
         octal <= 1'b0;
         discards <= 8'h00;
         strap_cnt <= 2'h0;
         strap_done <= 1'b0;
      end else if (i_clock_en) begin
         // The strap is taken once, after the synchroniser has filled.
         if (strap_cnt != ddr_switch_pkg::STRAP_WAIT) begin
            strap_cnt <= strap_cnt + 2'h1;
         end else if (!strap_done) begin
            strap_done <= 1'b1;
            octal <= pin_s3[3]; // see R12
         end
         if (rearm) begin
            slot <= 3'h0;
            octal <= 1'b0;
            pending <= 1'b0;
            chk_state <= S_FETCH_A;
         end else begin
            case (chk_state)
               S_IDLE: begin
                  if (frame_end && slot < ddr_switch_pkg::NUM_SLOTS) begin // see R1
                     pending <= 1'b1;
                     chk_state <= S_FETCH_A;
                  end
               end
               S_FETCH_A: begin
                  chk_state <= S_FETCH_B;
               end
               S_FETCH_B: begin
                  word_a <= tbl_bus.rd_data;
                  chk_state <= S_CHECK;
               end
               S_CHECK: begin
                  if (!live || accept) begin
                     // Advancing one slot at a time keeps the enable-then-write order.
                     slot <= slot + 3'h1; // see R9
                     pending <= pending && !accept;
                     if (last_slot) begin
                        octal <= 1'b1; // see R10
                        pending <= 1'b0;
                        chk_state <= S_IDLE;
                     end else begin
                        chk_state <= S_FETCH_A;
                     end
                  end else begin
                     if (reject) begin
                        discards <= discards + 8'h01; // see R8
                     end
                     pending <= 1'b0;
                     chk_state <= S_IDLE;
                  end
               end
               default: chk_state <= S_IDLE;
            endcase
         end
      end
   end

   // Settings take effect only as a whole, once every sequence has been seen or the octal boot strap has been taken.
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_octal_ddr <= 1'b0;
         o_drv_type <= ddr_switch_pkg::DRV_BOOT;
         o_dummy_cycles <= ddr_switch_pkg::BOOT_DUMMY;
      end else if (i_clock_en) begin
         o_octal_ddr <= octal;
         o_drv_type <= octal ? ddr_switch_pkg::DRV_TYPE0 : ddr_switch_pkg::DRV_BOOT; // see R10
         o_dummy_cycles <= octal ? ddr_switch_pkg::OCT_DUMMY : ddr_switch_pkg::BOOT_DUMMY;
      end
   end

   // ==========================================================================
   // Checks
   // ==========================================================================
   clock_count_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      accept |-> (bit_cnt[2:0] == 3'h0) && (bit_cnt[15:3] == {5'h00, seq_len}) && (seq_len <= 8'h07)) // see R7
      else $error("sequence accepted with a wrong clock count");

   discard_count_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (reject && i_clock_en && !rearm) |=> (discards == $past(discards) + 8'h01) && (slot == $past(slot))) // see R8
      else $error("mismatched frame not discarded");

   slot_order_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      ($changed(slot) && !$past(rearm)) |-> (slot == $past(slot) + 3'h1)) // see R9
      else $error("slot order skipped or reversed");

   slot_bound_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      slot <= 3'h4) // see R6
      else $error("more than four slots in use");

   octal_settings_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      ($rose(octal) && i_clock_en) |=> o_octal_ddr && (o_drv_type == 3'h0) && (o_dummy_cycles == 5'h14)) // see R10
      else $error("octal settings not applied");

   table_length_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      accept |-> ({4'h0, slot, 1'b0} + 8'h02 <= ctrl.tbl_len)) // see R14
      else $error("slot beyond table length accepted");

   header_first_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (sel_hdr0 && i_clock_en) |=> (rd_word[15:0] == 16'h000A) && (rd_word[23:16] == 8'h01)
         && (rd_word[31:24] == ctrl.tbl_len)) // see R15
      else $error("first header word wrong");

   header_second_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (sel_hdr1 && i_clock_en) |=> (rd_word[31:24] == 8'hFF) && (rd_word[1:0] == 2'h0)) // see R17
      else $error("second header word wrong");

   silent_octal_a: assert property (@(posedge i_clock) disable iff (i_sys_rst)
      (octal && cs_active && !rearm) |=> ##1 o_so_oe_n) // see R11
      else $error("parameter read answered in octal mode");

endmodule : ddr_switch_target

`default_nettype wire

//--- test/host_model.sv
// Host side of the single-line serial bus: frames bytes and reads parameter words.
// Assumes the bench clock paces every pin change; the serial clock idles low between frames.
`default_nettype none

module host_model #(
   parameter int HALF = 8
) (
   input wire logic i_clock,
   output logic o_cs_n,
   output logic o_sck,
   output logic o_si,
   input wire logic i_so
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_si = 1'b0;
   end

   // =========================================================================
   // Frame tasks
   // =========================================================================
   task automatic ticks(input int n);
      repeat (n) @(posedge i_clock);
   endtask : ticks

   // The gap after the frame leaves the target time to judge it before the next one.
   task automatic shift(input logic [79:0] v, input int n, output logic [79:0] r);
      r = '0;
      @(posedge i_clock);
      o_cs_n <= 1'b0;
      for (int k = n - 1; k >= 0; k--) begin
         o_si <= v[k];
         ticks(HALF);
         o_sck <= 1'b1;
         r = {r[78:0], i_so};
         ticks(HALF);
         o_sck <= 1'b0;
      end
      ticks(HALF);
      o_cs_n <= 1'b1;
      o_si <= ~o_si;
      ticks(4 * HALF);
   endtask : shift

   // Bytes arrive lowest address first, so the first byte is the least significant.
   task automatic read_word(input logic [23:0] a, output logic [31:0] w);
      logic [79:0] r;
      shift({8'h5A, a, 8'h00, 32'h0}, 72, r);
      w = {r[7:0], r[15:8], r[23:16], r[31:24]};
   endtask : read_word
endmodule : host_model

`default_nettype wire

//--- test/octal_ddr_switch_sequencer_tb.sv
// Self-checking bench for the octal DDR switch target with a host model on its serial pins.
// Assumes the register port answers reads one cycle later and never stalls.
`default_nettype none

module octal_ddr_switch_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clock, i_sys_rst, i_boot_octal, i_wr, i_rd, cs_n, sck, si, so, so_oe_n, octal;
   logic rd_seen = 1'b0;
   logic clock_en;
   // A released data line floats to its pull-up level.
   wire so_bus = so_oe_n ? 1'b1 : so;
   logic [7:0] i_addr;
   logic [31:0] i_wdata, o_rdata, r32;
   logic [31:0] w[8];
   logic [7:0] lens[4] = '{8'h01, 8'h03, 8'h00, 8'h07};
   logic [2:0] drv;
   logic [4:0] dummy;
   logic [31:0] exp_q[$];
   int miscompares = 0;
   int n_compared = 0;

   ddr_switch_target i_ddr_switch_target (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clock_en(clock_en),
      .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_boot_octal(i_boot_octal), .o_so(so), .o_so_oe_n(so_oe_n),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_octal_ddr(octal), .o_drv_type(drv), .o_dummy_cycles(dummy));
   host_model i_host (.i_clock(i_clock), .o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so_bus));

   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end

   // =========================================================================
   // Tasks
   // =========================================================================
   task automatic summarize();
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      exp_q.push_back(e);
      @(posedge i_clock);
      i_rd <= 1'b0;
   endtask : rd

   // Sends the stored bytes of a slot, right-aligned, with the given clock count.
   task automatic send_slot(input int s, input int nbits);
      logic [79:0] v, r;
      v = {24'h0, w[2 * s][23:0], w[2 * s + 1]} >> (8 * (7 - w[2 * s][31:24]));
      i_host.shift(v, nbits, r);
   endtask : send_slot

   task automatic wait_octal();
      for (int k = 0; k < 200 && octal !== 1'b1; k++) @(posedge i_clock);
      if (octal !== 1'b1) begin
         miscompares++;
         $display("ERROR at %0t: octal mode never entered", $time);
         summarize();
      end
      repeat (2) @(posedge i_clock);
   endtask : wait_octal

   always @(posedge i_clock) begin
      rd_seen <= i_rd;
      if (rd_seen) check(o_rdata, exp_q.pop_front());
   end

   // =========================================================================
   // Main sequence
   // =========================================================================
   initial begin
      i_sys_rst = 1'b1;
      i_boot_octal = 1'b0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h00;
      i_wdata = 32'h0;
      clock_en = 1'b1;
      void'($urandom(32'hE742));
      repeat (8) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      repeat (8) @(posedge i_clock);
      check({23'h0, octal, drv, dummy}, {23'h0, 1'b0, 3'h1, 5'h08});
      i_host.read_word(24'h000008, r32);
      check(r32, {8'h08, 8'h01, 8'h00, 8'h0A});
      i_host.read_word(24'h00000C, r32);
      check(r32, {8'hFF, 24'h000030});
      $display("test header done");
      for (int i = 0; i < 8; i++) begin
         r32 = $urandom();
         w[i] = (i % 2 == 0) ? {lens[i / 2], r32[23:0]} : r32;
         wr(8'(4 * i), w[i]);
      end
      wr(8'h20, 32'h108);
      rd(8'h00, 32'h0);
      rd(8'h40, 32'h0);
      rd(8'h20, 32'h8);
      i_host.read_word(24'h000030, r32);
      check(r32, w[0]);
      rd(8'h24, 32'h0);
      $display("test load done");
      send_slot(0, 7);
      send_slot(0, 9);
      send_slot(1, 24);
      rd(8'h24, 32'h300);
      send_slot(0, 8);
      send_slot(1, 24);
      rd(8'h24, 32'h306);
      send_slot(3, 56);
      wait_octal();
      check({23'h0, octal, drv, dummy}, {23'h0, 1'b1, 3'h0, 5'h14});
      i_host.read_word(24'h000008, r32);
      check(r32, 32'hFFFFFFFF);
      clock_en <= 1'b0;
      wr(8'h20, 32'h5);
      clock_en <= 1'b1;
      rd(8'h20, 32'h8);
      $display("test switch done");
      wr(8'h20, 32'h104);
      i_host.read_word(24'h000008, r32);
      check(r32, {8'h04, 8'h01, 8'h00, 8'h0A});
      send_slot(0, 8);
      send_slot(1, 24);
      wait_octal();
      check({23'h0, octal, drv, dummy}, {23'h0, 1'b1, 3'h0, 5'h14});
      $display("test short table done");
      i_boot_octal <= 1'b1;
      i_sys_rst <= 1'b1;
      repeat (8) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      wait_octal();
      check({23'h0, octal, drv, dummy}, {23'h0, 1'b1, 3'h0, 5'h14});
      $display("test boot strap done");
      repeat (3) @(posedge i_clock);
      summarize();
   end
endmodule : octal_ddr_switch_sequencer_tb

`default_nettype wire
